// ===== hw/port_caps_pkg.sv
// Constants for the per-port device status and link capability registers.
// Assumes a 32-bit Avalon-MM slave with word offsets as byte addresses.
package port_caps_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_DEV_CTRL_STATUS = 8'hC8;
    localparam logic [7:0] OFF_LINK_CAPS = 8'hCC;
    localparam logic [7:0] OFF_OVERRIDE = 8'hE0;
    localparam logic [7:0] OFF_EVENT_COUNT = 8'hE4;

    // ==========================================================
    // Device control / status fields
    localparam int CORR_EN_BIT = 0;
    localparam int ERR_EN_LSB = 0;
    localparam int ERR_DET_LSB = 16;
    localparam int CORR_DET_BIT = 16;
    localparam int NONFATAL_DET_BIT = 17;
    localparam int FATAL_DET_BIT = 18;
    localparam int UNSUP_DET_BIT = 19;
    localparam int AUX_PWR_BIT = 20;
    localparam int TRANS_PEND_BIT = 21;
    localparam logic [3:0] ERR_EN_RESET = 4'h0;
    localparam logic AUX_PWR_RESET = 1'b1;
    localparam logic TRANS_PEND_VALUE = 1'b0;

    // ==========================================================
    // Link capability fields
    localparam int SPEED_LSB = 0;
    localparam int WIDTH_LSB = 4;
    localparam int ACTIVE_STATE_POWER_MGMT_LSB = 10;
    localparam int L0S_LSB = 12;
    localparam int L1_LSB = 15;
    localparam int CLK_PM_BIT = 18;
    localparam int SURPRISE_BIT = 19;
    localparam int DLL_ACTIVE_BIT = 20;
    localparam int BW_NOTIFY_BIT = 21;
    localparam int PORT_NUM_LSB = 24;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [3:0] SPEED_5G0 = 4'h2;
    localparam logic [3:0] SPEED_RESET = 4'h2;
    localparam logic [5:0] WIDTH_RESET = 6'h01;
    localparam logic [1:0] ACTIVE_STATE_POWER_MGMT_RESET = 2'h3;
    localparam logic [2:0] L0S_RESET = 3'h3;
    localparam logic [2:0] L1_RESET = 3'h0;
    localparam logic DLL_ACTIVE_VALUE = 1'b0;

    // Exit latencies as printed, and derived 50 MHz cycle counts
    localparam int CLK_PERIOD_NS = 20;
    localparam int L0S_EXIT_MIN_NS = 256;
    localparam int L1_EXIT_MIN_NS = 16000;
    localparam int L0S_EXIT_CYC =
        (L0S_EXIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int L1_EXIT_CYC =
        (L1_EXIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Override register: 17:10 port number, 8 clock PM, 7:5 L1,
    // 4:2 L0s, 1:0 power-mgmt support; bit 31 selects the override
    localparam int OVR_ENABLE_BIT = 31;

    // Bus answer for unmapped reads
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Bus slave state
    typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage : port_caps_pkg

// ===== hw/error_flag_bank.sv
// Sticky error-detected flags with write-one-to-clear.
// Assumes single-cycle event pulses synchronous to ref_clk_i.
`timescale 1ns/1ns
module error_flag_bank (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Events and clears
    input wire logic [3:0] event_i,
    input wire logic [3:0] clear_i,
    // Flags
    output logic [3:0] flag_o
);
    import port_caps_pkg::*;

    // ==========================================================
    // One sticky flag per error class; set beats clear
    genvar g;
    wire [3:0] next_flag;
    generate
        for (g = 0; g < 4; g++) begin : gen_flag
            assign next_flag[g] = event_i[g] | (flag_o[g] & ~clear_i[g]);
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flag_o <= 4'h0;
        end else if (clk_en_i) begin
            flag_o <= next_flag;
        end
    end

    // ==========================================================
    AST_SET_WINS: assert property ( // R01
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && event_i[0] |=> flag_o[0])
        else $error("Correctable flag lost an event");
    AST_CLR_ONLY: assert property ( // R03
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && clear_i[2] && !event_i[2] |=> !flag_o[2])
        else $error("Fatal flag not cleared");

endmodule : error_flag_bank

// ===== hw/read_data_reg.sv
// Registered read-data holder for the bus slave.
// Assumes load is a one-cycle strobe in the bus clock domain.
`timescale 1ns/1ns
module read_data_reg (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Load side
    input wire logic load_i,
    input wire logic [31:0] data_i,
    // Held data
    output logic [31:0] data_o
);
    import port_caps_pkg::*;

    // ==========================================================
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_o <= UNMAPPED_DATA;
        end else if (clk_en_i && load_i) begin
            data_o <= data_i;
        end
    end

endmodule : read_data_reg

// ===== hw/pcie_port_dev_status_link_caps.sv
// Per-port device status and link capability registers of a switch port.
// Assumes an Avalon-MM master on ref_clk_i and error pulses on that clock.
//
// What this block does
// R01: Correctable-error flag at bit 16 sets on event, write-one clears.
// R02: Non-fatal-error flag at bit 17 sets on event, write-one clears.
// R03: Fatal-error flag at bit 18 sets on event, write-one clears.
// R04: Unsupported-request flag at bit 19 sets on event, write-one clears.
// R05: Flags log errors whatever the reporting enables hold.
// R06: AUX power detected at bit 20, read-only, resets to one.
// R07: Transactions pending at bit 21 always reads zero.
// R08: Max link speed bits 3:0 read 0010b, 5.0 Gb/s.
// R09: Max link width bits 9:4 read x1.
// R10: Power-management support bits 11:10 reset to 11b.
// R11: L0s exit latency bits 14:12 reset to 011b.
// R12: L1 exit latency bits 17:15 reset to 000b.
// R13: Clock PM bit 18 is one upstream, zero downstream.
// R14: Surprise-down bit 19 is zero upstream, one downstream.
// R15: Link-active reporting bit 20 reads zero on every port.
// R16: Bandwidth notify bit 21 zero upstream, one downstream.
// R17: Port number bits 31:24 reset to the port index.
// R18: Power-management, latency, clock PM, port number fields overridable.
// R19: Reporting enables in control bits 3:0 reset to zero.
// R20: Zero writes to flags and writes to read-only bits are ignored.
`timescale 1ns/1ns
module pcie_port_dev_status_link_caps #(
    parameter logic [1:0] PORT_INDEX = 2'h0
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Error events from the port core
    input wire logic corr_err_i,
    input wire logic nonfatal_err_i,
    input wire logic fatal_err_i,
    input wire logic unsup_req_i,
    // AUX power sense
    input wire logic aux_power_i,
    // Auto-load path from SMBus or EEPROM
    input wire logic autoload_valid_i,
    input wire logic [31:0] autoload_data_i,
    // Reporting outputs
    output logic [3:0] err_report_o,
    output logic [1:0] active_state_power_mgmt_o,
    output logic clock_request_pin_en_o
);
    import port_caps_pkg::*;

    // ==========================================================
    // Static port role
    wire upstream;
    assign upstream = (PORT_INDEX == 2'h0);

    // ==========================================================
    // State
    bus_state_t bus_state;
    logic [3:0] err_en;
    logic aux_seen;
    logic [1:0] active_state_power_mgmt_sup;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
    logic clk_pm;
    logic [7:0] port_num;
    logic ovr_enable;
    logic [15:0] event_count;
    logic [3:0] flags;

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    wire bus_idle;
    wire wr_take;
    wire rd_take;
    wire wr_ctrl;
    wire wr_ovr;
    wire [3:0] clr_bits;
    wire [3:0] events;
    wire [7:0] byte0_mask;
    assign bus_idle = (bus_state == BUS_IDLE);
    assign wr_take = bus_idle && avs_write;
    assign rd_take = bus_idle && avs_read;
    assign wr_ctrl = wr_take && hit(avs_address, OFF_DEV_CTRL_STATUS);
    assign wr_ovr = wr_take && hit(avs_address, OFF_OVERRIDE)
        && (&avs_byteenable);
    // Flags live in byte 2; only a one written there clears
    assign clr_bits = (wr_ctrl && avs_byteenable[2]) ?
        avs_writedata[ERR_DET_LSB +: 4] : 4'h0; // R20
    // Logging ignores err_en entirely
    assign events = {unsup_req_i, fatal_err_i, nonfatal_err_i,
        corr_err_i}; // R05
    assign byte0_mask = avs_byteenable[0] ? 8'hFF : 8'h00;

    // ==========================================================
    // Sticky flags
    error_flag_bank u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .event_i(events), // R01 R02 R03 R04
        .clear_i(clr_bits),
        .flag_o(flags)
    );

    // ==========================================================
    // Register images
    wire [31:0] status_word;
    wire [31:0] caps_word;
    wire [31:0] ovr_word;
    wire [31:0] read_mux;
    assign status_word = {10'h000, TRANS_PEND_VALUE, aux_seen, flags,
        12'h000, err_en}; // R07
    assign caps_word = {port_num, 2'h0, ~upstream, DLL_ACTIVE_VALUE,
        ~upstream, clk_pm, l1_lat, l0s_lat, active_state_power_mgmt_sup, WIDTH_RESET,
        SPEED_RESET}; // R08 R09 R14 R15 R16
    assign ovr_word = {ovr_enable, 13'h0000, port_num, 1'b0, clk_pm,
        l1_lat, l0s_lat, active_state_power_mgmt_sup};
    assign read_mux =
        hit(avs_address, OFF_DEV_CTRL_STATUS) ? status_word :
        hit(avs_address, OFF_LINK_CAPS) ? caps_word :
        hit(avs_address, OFF_OVERRIDE) ? ovr_word :
        hit(avs_address, OFF_EVENT_COUNT) ? {16'h0000, event_count} :
        UNMAPPED_DATA;

    read_data_reg u_rdata (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .load_i(rd_take),
        .data_i(read_mux),
        .data_o(avs_readdata)
    );

    // ==========================================================
    // Bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (clk_en_i) begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state <= BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Device control reporting enables
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            err_en <= ERR_EN_RESET; // R19
        end else if (clk_en_i && wr_ctrl) begin
            err_en <= (avs_writedata[3:0] & byte0_mask[3:0])
                | (err_en & ~byte0_mask[3:0]);
        end
    end

    // ==========================================================
    // AUX power: reads one out of reset, then tracks the sense input
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aux_seen <= AUX_PWR_RESET; // R06
        end else if (clk_en_i) begin
            aux_seen <= aux_power_i;
        end
    end

    // ==========================================================
    // Overridable capability fields; auto-load wins over a bus write
    wire ovr_load;
    wire [31:0] ovr_src;
    wire [1:0] ovr_active_state_power_mgmt;
    assign ovr_load = autoload_valid_i || wr_ovr; // R18
    assign ovr_src = autoload_valid_i ? autoload_data_i : avs_writedata;
    assign ovr_active_state_power_mgmt = ovr_src[1:0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_state_power_mgmt_sup <= ACTIVE_STATE_POWER_MGMT_RESET; // R10
            l0s_lat <= L0S_RESET; // R11
            l1_lat <= L1_RESET; // R12
            clk_pm <= upstream; // R13
            port_num <= {6'h00, PORT_INDEX}; // R17
            ovr_enable <= 1'b0;
        end else if (clk_en_i && ovr_load) begin
            ovr_enable <= ovr_src[OVR_ENABLE_BIT];
            if (ovr_src[OVR_ENABLE_BIT]) begin
                active_state_power_mgmt_sup <= ovr_src[1:0]; // R18
                l0s_lat <= ovr_src[4:2];
                l1_lat <= ovr_src[7:5];
                clk_pm <= ovr_src[8];
                port_num <= ovr_src[17:10];
            end
        end
    end

    // ==========================================================
    // Error event counter, saturating, for software diagnostics
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            event_count <= 16'h0000;
        end else if (clk_en_i && (|events) && (event_count != 16'hFFFF)) begin
            event_count <= event_count + 16'h0001;
        end
    end

    // ==========================================================
    // Reporting: an enabled class forwards its error as a pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            err_report_o <= 4'h0;
            active_state_power_mgmt_o <= ACTIVE_STATE_POWER_MGMT_RESET;
            clock_request_pin_en_o <= 1'b0;
        end else if (clk_en_i) begin
            err_report_o <= events & err_en; // R19
            active_state_power_mgmt_o <= active_state_power_mgmt_sup;
            clock_request_pin_en_o <= clk_pm & upstream;
        end
    end

    // ==========================================================
    // Checks: error flags
    AST_CORR_LOG: assert property ( // R01
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && corr_err_i ##1 clk_en_i && rd_take
        && hit(avs_address, OFF_DEV_CTRL_STATUS)
        |=> avs_readdata[CORR_DET_BIT])
        else $error("Correctable flag not visible");
    AST_NONFATAL: assert property ( // R02
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && nonfatal_err_i |=> flags[1])
        else $error("Non-fatal flag not set");
    AST_NONFATAL_CLR: assert property ( // R02
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && wr_ctrl && avs_byteenable[2]
        && avs_writedata[NONFATAL_DET_BIT] && !nonfatal_err_i |=> !flags[1])
        else $error("Non-fatal flag not cleared");
    AST_UNSUP: assert property ( // R04
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && unsup_req_i |=> flags[3])
        else $error("Unsupported flag not set");
    AST_LOG_NO_EN: assert property ( // R05
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && fatal_err_i && !err_en[2]
        |=> flags[2] && !err_report_o[2])
        else $error("Fatal logging tied to enable");
    AST_COUNT_INC: assert property ( // R05
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && (|events) && event_count != 16'hFFFF
        |=> event_count == $past(event_count) + 16'h0001)
        else $error("Event counter missed an error");
    AST_REPORT: assert property ( // R19
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && nonfatal_err_i && err_en[1] |=> err_report_o[1])
        else $error("Enabled non-fatal error not reported");
    AST_ZERO_WRITE: assert property ( // R20
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && wr_ctrl && avs_writedata[19:16] == 4'h0 && flags[0]
        |=> flags[0])
        else $error("Zero write cleared a flag");

    // ==========================================================
    // Checks: status and capability images
    AST_PEND_ZERO: assert property ( // R07
        @(posedge ref_clk_i) disable iff (rst_i)
        status_word[TRANS_PEND_BIT] == 1'b0 && status_word[31:22] == 10'h000)
        else $error("Pending bit not zero");
    AST_SPEED: assert property ( // R08
        @(posedge ref_clk_i) disable iff (rst_i)
        caps_word[3:0] == SPEED_5G0 && caps_word[9:4] == WIDTH_RESET)
        else $error("Speed or width wrong");
    AST_ROLE_BITS: assert property ( // R14
        @(posedge ref_clk_i) disable iff (rst_i)
        caps_word[SURPRISE_BIT] == caps_word[BW_NOTIFY_BIT]
        && caps_word[SURPRISE_BIT] == !upstream
        && !caps_word[DLL_ACTIVE_BIT])
        else $error("Port role bits wrong");
    AST_CLOCK_REQUEST_PIN: assert property ( // R13
        @(posedge ref_clk_i) disable iff (rst_i)
        clock_request_pin_en_o |-> upstream)
        else $error("Clock request enabled on a downstream port");
    AST_AUX_FOLLOW: assert property ( // R06
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i |=> aux_seen == $past(aux_power_i))
        else $error("AUX power bit does not follow its sense");
    AST_CAPS_RO: assert property ( // R20
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_take && hit(avs_address, OFF_LINK_CAPS) && !autoload_valid_i
        |=> $stable(caps_word))
        else $error("Write changed link capabilities");
    AST_OVR_LOAD: assert property ( // R18
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && ovr_load && ovr_src[OVR_ENABLE_BIT]
        |=> active_state_power_mgmt_sup == $past(ovr_active_state_power_mgmt) && ovr_enable)
        else $error("Override not applied");
    AST_OVR_PARTIAL: assert property ( // R20
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_take && hit(avs_address, OFF_OVERRIDE) && !(&avs_byteenable)
        && !autoload_valid_i |=> $stable(ovr_word))
        else $error("Partial override write took effect");
    AST_RESET_CAPS: assert property ( // R17
        @(posedge ref_clk_i)
        $fell(rst_i) |-> active_state_power_mgmt_sup == ACTIVE_STATE_POWER_MGMT_RESET && l0s_lat == L0S_RESET
        && l1_lat == L1_RESET && port_num == {6'h00, PORT_INDEX})
        else $error("Capability reset values wrong");
    AST_RESET_OUT: assert property ( // R06
        @(posedge ref_clk_i)
        $fell(rst_i) |-> avs_waitrequest && err_report_o == 4'h0
        && avs_readdata == UNMAPPED_DATA && aux_seen == AUX_PWR_RESET
        && active_state_power_mgmt_o == ACTIVE_STATE_POWER_MGMT_RESET && !clock_request_pin_en_o)
        else $error("Outputs wrong after reset");

    // ==========================================================
    // Checks: bus handshake, one answer cycle per request
    AST_WAIT_ONE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && bus_idle && avs_read |=> !avs_waitrequest)
        else $error("Read not answered in one cycle");
    AST_WAIT_HIGH: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && !avs_waitrequest |=> avs_waitrequest)
        else $error("Answer held longer than one cycle");
    AST_RDATA_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !rd_take |=> $stable(avs_readdata))
        else $error("Read data changed without a read");

endmodule : pcie_port_dev_status_link_caps

// ===== tb/port_core_model.sv
// Model of the port core and side-port loader that feed the block.
// Assumes its tasks are called just after a rising edge of ref_clk_i.
`timescale 1ns/1ns
module port_core_model (
    // Clock
    input wire logic ref_clk_i,
    // Error events and auto-load word
    output logic [3:0] err_o,
    output logic load_valid_o,
    output logic [31:0] load_data_o
);
    // ==========================================================
    // Drivers
    initial begin
        err_o = 4'h0;
        load_valid_o = 1'b0;
        load_data_o = 32'h0000_0000;
    end

    task automatic pulse(input int idx);
        @(posedge ref_clk_i);
        err_o <= 4'h1 << idx;
        @(posedge ref_clk_i);
        err_o <= 4'h0;
    endtask : pulse

    // Data inverted after the strobe, so a late sample shows up
    task automatic load(input logic [31:0] d);
        @(posedge ref_clk_i);
        load_valid_o <= 1'b1;
        load_data_o <= d;
        @(posedge ref_clk_i);
        load_valid_o <= 1'b0;
        load_data_o <= ~d;
    endtask : load
endmodule : port_core_model

// ===== tb/tb.sv
// Self-checking bench: one upstream and one downstream port instance.
// Assumes the Avalon-MM timing and override layout of the design notes.
`timescale 1ns/1ns
module tb;
    import port_caps_pkg::*;
    typedef struct {
        logic [31:0] e0;
        logic [31:0] e1;
        logic [31:0] m;
    } note_t;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_C8 = 32'hFFFF_000F;
    logic ref_clk_i, rst_i, avs_read, avs_write, aux_power_i;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable, ev, shadow_en, flags, exp_rep, en;
    logic ld_v;
    logic [31:0] ld_d;
    logic clk_en;
    wire [31:0] rdata [2];
    wire wreq [2];
    wire [3:0] rep [2];
    wire [1:0] active_state_power_mgmt [2];
    wire cke [2];
    logic [17:0] o0, o1;
    note_t notes [$];
    note_t nt;
    int num_errors, check_count, seed;

    // ==========================================================
    // Design and partner
    for (genvar g = 0; g < 2; g++) begin : g_port
        pcie_port_dev_status_link_caps #(.PORT_INDEX(2'(g * 2))) uut (
            .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
            .avs_address(avs_address), .avs_read(avs_read),
            .avs_write(avs_write), .avs_writedata(avs_writedata),
            .avs_byteenable(avs_byteenable), .avs_readdata(rdata[g]),
            .avs_waitrequest(wreq[g]), .corr_err_i(ev[0]),
            .nonfatal_err_i(ev[1]), .fatal_err_i(ev[2]),
            .unsup_req_i(ev[3]), .aux_power_i(aux_power_i),
            .autoload_valid_i(ld_v), .autoload_data_i(ld_d),
            .err_report_o(rep[g]), .active_state_power_mgmt_o(active_state_power_mgmt[g]),
            .clock_request_pin_en_o(cke[g]));
    end
    port_core_model pm (.ref_clk_i(ref_clk_i), .err_o(ev),
        .load_valid_o(ld_v), .load_data_o(ld_d));

    // ==========================================================
    // Helpers
    function logic [17:0] dflt(input logic [7:0] p, input logic c);
        return {p, 1'b0, c, L1_RESET, L0S_RESET, ACTIVE_STATE_POWER_MGMT_RESET};
    endfunction : dflt

    function logic [31:0] caps(input logic up, input logic [17:0] o);
        return {o[17:10], 2'h0, !up, DLL_ACTIVE_VALUE, !up, o[8],
                o[7:5], o[4:2], o[1:0], WIDTH_RESET, SPEED_RESET};
    endfunction : caps

    function logic [31:0] ovr(input logic [17:0] o);
        return {1'b1, 13'h0, o[17:10], 1'b0, o[8:0]};
    endfunction : ovr

    function logic [31:0] c8(input logic aux);
        return {10'h0, TRANS_PEND_VALUE, aux, flags, 12'h0, shadow_en};
    endfunction : c8

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wreq[0] !== 1'b0 && n < 40);
        if (wreq[0] !== 1'b0) begin
            num_errors++;
            $display("wrong value at %0t: bus hang", $time);
        end
        chk({31'h0, wreq[1]}, 32'h0);
        if (w && a == OFF_DEV_CTRL_STATUS && be[0]) shadow_en <= d[3:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 8'($random(seed));
        avs_writedata <= ~d;
        @(posedge ref_clk_i);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e0,
                      input logic [31:0] e1, input logic [31:0] m);
        notes.push_back('{e0, e1, m});
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd

    // ==========================================================
    // Clock, monitor, watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (avs_read && wreq[0] === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk(rdata[0] & nt.m, nt.e0 & nt.m);
            chk(rdata[1] & nt.m, nt.e1 & nt.m);
        end
        if (!rst_i) begin
            chk({28'h0, rep[0]}, {28'h0, exp_rep});
            chk({28'h0, rep[1]}, {28'h0, exp_rep});
        end
        exp_rep <= rst_i ? 4'h0 : clk_en ? ev & shadow_en : exp_rep;
    end

    initial begin
        #100000;
        num_errors++;
        summarize();
    end

    // ==========================================================
    // Scenarios
    initial begin
        seed = 68108;
        num_errors = 0;
        check_count = 0;
        rst_i = 1'b1;
        clk_en = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        aux_power_i = 1'b1;
        shadow_en = 4'h0;
        flags = 4'h0;
        exp_rep = 4'h0;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(OFF_DEV_CTRL_STATUS, c8(1'b1), c8(1'b1), MASK_C8);
        aux_power_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rd(OFF_DEV_CTRL_STATUS, c8(1'b0), c8(1'b0), MASK_C8);
        o0 = dflt(8'h00, 1'b1);
        o1 = dflt(8'h02, 1'b0);
        rd(OFF_LINK_CAPS, caps(1'b1, o0), caps(1'b0, o1), ALL);
        chk({30'h0, active_state_power_mgmt[1]}, {30'h0, ACTIVE_STATE_POWER_MGMT_RESET});
        chk({31'h0, cke[0]}, 32'h1);
        chk({31'h0, cke[1]}, 32'h0);
        // Junk write to a read-only word, random lanes
        bus(1'b1, OFF_LINK_CAPS, $random(seed), 4'($random(seed)));
        rd(OFF_LINK_CAPS, caps(1'b1, o0), caps(1'b0, o1), ALL);
        rd(8'h40, 32'h0, 32'h0, ALL);
        // Enables kept low for even errors: logging must not depend
        for (int i = 0; i < 4; i++) begin
            en = 4'($random(seed));
            en[i] = i[0];
            bus(1'b1, OFF_DEV_CTRL_STATUS, {28'h0, en}, 4'hF);
            pm.pulse(i);
            flags[i] = 1'b1;
            rd(OFF_DEV_CTRL_STATUS, c8(1'b0), c8(1'b0), MASK_C8);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFF_DEV_CTRL_STATUS,
                {12'h0, 4'h1 << i, 12'h0, shadow_en}, 4'hF);
            flags[i] = 1'b0;
            rd(OFF_DEV_CTRL_STATUS, c8(1'b0), c8(1'b0), MASK_C8);
        end
        // Frozen block must ignore an error pulse
        clk_en <= 1'b0;
        pm.pulse(0);
        clk_en <= 1'b1;
        rd(OFF_DEV_CTRL_STATUS, c8(1'b0), c8(1'b0), MASK_C8);
        rd(OFF_EVENT_COUNT, 32'h4, 32'h4, ALL);
        // Bus override first, then the loader path
        for (int k = 0; k < 2; k++) begin
            o0 = 18'($random(seed));
            o0[8] = 1'b0;
            if (k == 0) begin
                bus(1'b1, OFF_OVERRIDE, {1'b1, 13'h0, o0}, 4'hF);
            end else begin
                pm.load({1'b1, 13'h0, o0});
            end
            rd(OFF_LINK_CAPS, caps(1'b1, o0), caps(1'b0, o0), ALL);
            rd(OFF_OVERRIDE, ovr(o0), ovr(o0), ALL);
            chk({30'h0, active_state_power_mgmt[0]}, {30'h0, o0[1:0]});
            chk({31'h0, cke[0]}, 32'h0);
        end
        // Override needs every byte lane
        bus(1'b1, OFF_OVERRIDE, 32'h0000_0000, 4'h7);
        rd(OFF_OVERRIDE, ovr(o0), ovr(o0), ALL);
        summarize();
    end
endmodule : tb
